// ### design/slave_pkg.sv
// Constants shared by the external bus slave, the bus master model and the testbench.
`default_nettype none
package slave_pkg;
	// Pin widths of the nonmultiplexed bus.
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	// Size codes driven by the master on size_code_hi/size_code_lo.
	localparam logic [1:0] SIZE_LONG  = 2'h0;
	localparam logic [1:0] SIZE_BYTE  = 2'h1;
	localparam logic [1:0] SIZE_WORD  = 2'h2;
	localparam logic [1:0] SIZE_THREE = 2'h3;
	// Byte lane mask: bit 1 is data[15:8], bit 0 is data[7:0].
	localparam logic [1:0] LANE_UPPER = 2'h2;
	localparam logic [1:0] LANE_BOTH  = 2'h3;
	// Default decode window and response timing.
	localparam logic [23:0] BASE_DEFAULT = 24'h000000;
	localparam logic [23:0] MASK_DEFAULT = 24'hff0000;
	localparam int          ACK_WAIT_DEFAULT = 0;
	localparam int          FIFO_DEPTH_DEFAULT = 16;
	// Responder states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_ACK  = 2'b10,
		ST_ERR  = 2'b11
	} resp_state_e;
endpackage : slave_pkg
`default_nettype wire

// ### design/word_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             clock_in,
	input  wire logic             rst_n_in,
	// Filling side.
	input  wire logic [WIDTH-1:0] push_data_in,
	input  wire logic             push_valid_in,
	output logic                  push_ready_out,
	// Draining side.
	output logic [WIDTH-1:0]      pop_data_out,
	output logic                  pop_valid_out,
	input  wire logic             pop_ready_in
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [PW:0]      count_r;
	logic             do_push;
	logic             do_pop;

	// Full and empty come straight from the occupancy count.
	assign push_ready_out = (count_r != (PW+1)'(DEPTH));
	assign pop_valid_out  = (count_r != '0);
	assign pop_data_out   = mem_r[rd_ptr_r];
	assign do_push        = push_valid_in && push_ready_out;
	assign do_pop         = pop_valid_out && pop_ready_in;

	// Storage has no reset; only pointers and count are control state.
	always_ff @(posedge clock_in) begin
		if (do_push) begin
			mem_r[wr_ptr_r] <= push_data_in;
		end
	end

	// Pointers wrap at DEPTH so that non-power-of-two depths also work.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
		end
	end

	// Occupancy count.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_r <= '0;
		end else if (do_push && !do_pop) begin
			count_r <= count_r + 1'b1;
		end else if (do_pop && !do_push) begin
			count_r <= count_r - 1'b1;
		end
	end
endmodule : word_fifo
`default_nettype wire

// ### design/bus_slave.sv
// Slave responder for the external asynchronous strobe/acknowledge bus.
`default_nettype none
// Behaviour
// - 16-bit read: data on 15:0, wide ack only.
// - Size bits and low address select lanes.
// - Supply or latch data, ack encodes width.
// - Bus error aborts; with retry, cycle reruns.
// - Ack must not lead read data too far.
// - Late bus error within limit after ack.
// - Ack held through strobe negation, no waits.
// - Late error meets setup one clock after.
// - Fast-termination device has data by state four.
// - Fast write needs strobe select on address.
// - Overlapping chip selects share one wait counter.
// - 8-bit port: byte on 15:8, narrow ack.
// - Release data and ack after strobe negation.
module bus_slave
	import slave_pkg::*;
#(
	parameter logic [ADDR_W-1:0] BASE     = BASE_DEFAULT,
	parameter logic [ADDR_W-1:0] MASK     = MASK_DEFAULT,
	parameter int                ACK_WAIT = ACK_WAIT_DEFAULT,
	parameter int                DEPTH    = FIFO_DEPTH_DEFAULT
) (
	// Clock and reset.
	input  wire logic              clock_in,
	input  wire logic              rst_n_in,
	// Bus pins driven by the master.
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              addr_valid_strobe_n_in,
	input  wire logic              data_strobe_n_in,
	input  wire logic              read_not_write_in,
	input  wire logic              size_code_hi_in,
	input  wire logic              size_code_lo_in,
	// Two-way data bus, split into its three signals.
	input  wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe_out,
	// Termination pins driven back to the master.
	output logic                   transfer_ack_wide_n_out,
	output logic                   transfer_ack_narrow_n_out,
	output logic                   bus_error_n_out,
	output logic                   retry_n_out,
	// Configuration: present an 8-bit port instead of a 16-bit one.
	input  wire logic              port_narrow_in,
	// Read data source on the user side.
	input  wire logic [DATA_W-1:0] rd_data_in,
	input  wire logic              rd_valid_in,
	output logic                   rd_ready_out,
	input  wire logic              retry_req_in,
	// Write data stream out of the FIFO.
	output logic [DATA_W-1:0]      wr_data_out,
	output logic [1:0]             wr_lanes_out,
	output logic                   wr_valid_out,
	input  wire logic              wr_ready_in
);
	localparam int WW = ACK_WAIT > 255 ? 16 : 8;

	resp_state_e       state_r;
	logic [WW-1:0]     wait_r;
	logic              retry_r;
	logic              rd_cycle_r;
	logic [DATA_W-1:0] data_r;
	logic              oe_r;
	logic [1:0]        size_code;
	logic [1:0]        lanes;
	logic              hit;
	logic              released;
	logic              push_valid;
	logic              push_ready;
	logic              acking;

	// Byte lanes from size code and low address bit; lower lane joins unless a lone upper byte, and an 8-bit port takes the upper lane only.
	function automatic logic [1:0] lane_fn(input logic [1:0] sz, input logic a0, input logic nar);
		logic [1:0] m;
		m = '0;
		if (nar) begin
			m = LANE_UPPER;
		end else begin
			m[1] = !a0;
			m[0] = a0 || (sz != SIZE_BYTE);
		end
		return m;
	endfunction : lane_fn

	assign size_code = {size_code_hi_in, size_code_lo_in};
	assign lanes     = lane_fn(size_code, addr_in[0], port_narrow_in);
	// The select is only looked at while the address strobe is low, so it follows that strobe.
	assign hit       = ((addr_in & MASK) == BASE);
	// The address strobe going away, or on a write the data strobe too, ends our drive; ack must not linger into the next cycle.
	assign released  = addr_valid_strobe_n_in || (rd_cycle_r ? 1'b0 : data_strobe_n_in);
	assign acking    = (state_r == ST_ACK);

	// A write is pushed only once the data strobe vouches for the bus contents.
	assign push_valid = (state_r == ST_WAIT) && (wait_r == '0) && !rd_cycle_r
		&& !data_strobe_n_in && !addr_valid_strobe_n_in;
	assign rd_ready_out = (state_r == ST_WAIT) && (wait_r == '0) && rd_cycle_r
		&& !retry_req_in && !addr_valid_strobe_n_in;

	// Width is encoded by which ack line goes low; errors never carry an ack.
	assign transfer_ack_wide_n_out   = !(acking && !port_narrow_in);
	assign transfer_ack_narrow_n_out = !(acking && port_narrow_in);
	assign bus_error_n_out           = !(state_r == ST_ERR);
	assign retry_n_out               = !(state_r == ST_ERR && retry_r);
	assign data_out                  = data_r;
	assign data_oe_out               = oe_r;

	// Cycle sequencing: decode, optional waits, ack until the strobes drop.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r    <= ST_IDLE;
			wait_r     <= '0;
			retry_r    <= 1'b0;
			rd_cycle_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					retry_r <= 1'b0;
					if (!addr_valid_strobe_n_in) begin
						rd_cycle_r <= read_not_write_in;
						wait_r     <= WW'(ACK_WAIT);
						state_r    <= hit ? ST_WAIT : ST_ERR;
					end
				end
				ST_WAIT: begin
					if (addr_valid_strobe_n_in) begin
						state_r <= ST_IDLE;
					end else if (wait_r != '0) begin
						wait_r <= wait_r - 1'b1;
					end else if (rd_cycle_r && retry_req_in) begin
						retry_r <= 1'b1;
						state_r <= ST_ERR;
					end else if (rd_cycle_r ? rd_valid_in : (push_valid && push_ready)) begin
						state_r <= ST_ACK;
					end
				end
				ST_ACK: begin
					if (released) begin
						state_r <= ST_IDLE;
					end
				end
				ST_ERR: begin
					if (addr_valid_strobe_n_in) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Read data is placed together with the ack, so ack never leads valid data.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_r <= '0;
			oe_r   <= 1'b0;
		end else if (rd_ready_out && rd_valid_in) begin
			oe_r <= 1'b1;
			if (port_narrow_in) begin
				data_r <= addr_in[0] ? {rd_data_in[7:0], 8'h00} : {rd_data_in[15:8], 8'h00};
			end else begin
				data_r <= rd_data_in;
			end
		end else if (acking && released) begin
			oe_r   <= 1'b0;
			data_r <= '0;
		end
	end

	// Written words queue here; a full FIFO holds off the ack as wait states.
	word_fifo #(
		.WIDTH(DATA_W + 2),
		.DEPTH(DEPTH)
	) u_wfifo (
		.clock_in      (clock_in),
		.rst_n_in      (rst_n_in),
		.push_data_in  ({lanes, data_in}),
		.push_valid_in (push_valid),
		.push_ready_out(push_ready),
		.pop_data_out  ({wr_lanes_out, wr_data_out}),
		.pop_valid_out (wr_valid_out),
		.pop_ready_in  (wr_ready_in)
	);

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	logic any_ack;
	assign any_ack = !transfer_ack_wide_n_out || !transfer_ack_narrow_n_out;

	sequence wr_accept_s;
		(state_r == ST_WAIT) && push_valid && push_ready;
	endsequence
	sequence ack_seen_s;
		##1 any_ack && !rd_cycle_r;
	endsequence

	ack_release_a: assert property (
		any_ack && released |=> !any_ack && !data_oe_out)
		else $error("ack or data still driven after strobe negation");
	ack_hold_a: assert property (
		any_ack && !addr_valid_strobe_n_in && !data_strobe_n_in |=> any_ack)
		else $error("ack dropped while strobes still asserted");
	bus_error_in_alone_a: assert property (
		!bus_error_n_out |-> !any_ack)
		else $error("bus error given together with an ack");
	retry_pair_a: assert property (
		!retry_n_out |-> !bus_error_n_out)
		else $error("retry without bus error");
	wide_ack_a: assert property (
		any_ack && !port_narrow_in |-> !transfer_ack_wide_n_out && transfer_ack_narrow_n_out)
		else $error("16-bit port gave wrong ack pair");
	narrow_ack_a: assert property (
		any_ack && port_narrow_in |-> transfer_ack_wide_n_out && data_out[7:0] == 8'h00)
		else $error("8-bit port gave wrong ack pair or lanes");
	read_data_a: assert property (
		any_ack && rd_cycle_r |-> data_oe_out)
		else $error("read ack without data on the bus");
	write_ack_a: assert property (
		wr_accept_s |-> ack_seen_s)
		else $error("accepted write not acknowledged next cycle");
	lane_byte_a: assert property (
		push_valid && !port_narrow_in && size_code == SIZE_BYTE
			|-> lanes == (addr_in[0] ? 2'h1 : LANE_UPPER))
		else $error("byte lane decode wrong for byte size");
	miss_error_a: assert property (
		state_r == ST_IDLE && !addr_valid_strobe_n_in && !hit |=> !bus_error_n_out)
		else $error("unmapped address not answered with bus error");
endmodule : bus_slave
`default_nettype wire

// ### test/bus_master_model.sv
// Behavioural bus master that runs strobe and acknowledge cycles on the slave.
`default_nettype none
module bus_master_model
	import slave_pkg::*;
(
	// Clock.
	input  wire logic              clock_in,
	// Pins driven toward the slave.
	output logic [ADDR_W-1:0]      addr_out,
	output logic                   as_n_out,
	output logic                   ds_n_out,
	output logic                   rnw_out,
	output logic [1:0]             size_out,
	// Resolved data bus and the slave's share of it.
	output logic [DATA_W-1:0]      bus_out,
	input  wire logic [DATA_W-1:0] sdata_in,
	input  wire logic              soe_in,
	// Terminations {wide, narrow, error, retry}, active low.
	input  wire logic [3:0]        term_n_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] wd_r = '0;
	logic [DATA_W-1:0] idle_r = 16'h3c5a;
	logic              drv_r = 1'b0;
	// A released bus never shows its last value, so stale data cannot pass.
	always @(posedge clock_in) idle_r <= ~idle_r + 16'h1;
	assign bus_out = soe_in ? sdata_in : (drv_r ? wd_r : idle_r);
	// Strobes start negated.
	initial begin
		addr_out = '0;
		as_n_out = 1'b1;
		ds_n_out = 1'b1;
		rnw_out = 1'b1;
		size_out = SIZE_WORD;
	end
	// One bus cycle; lim cuts the wait short after lim falling edges whenever no termination has come.
	task automatic cycle(input logic r, input logic [ADDR_W-1:0] a, input logic [1:0] sz,
		input logic [DATA_W-1:0] wd, input int lim, output logic [3:0] t,
		output logic [DATA_W-1:0] rd);
		int n;
		n = 0;
		addr_out = a;
		rnw_out = r;
		size_out = sz;
		as_n_out = 1'b0;
		// Write data and its strobe come two clocks late, so a slave that ignored
		// the data strobe would latch the floating bus instead.
		if (!r) begin
			repeat (2) @(posedge clock_in);
			#1;
		end
		wd_r = wd;
		drv_r = !r;
		ds_n_out = 1'b0;
		do begin
			@(negedge clock_in);
			n++;
		end while (term_n_in == 4'hf && n < lim);
		t = term_n_in;
		// Data is taken one falling edge after the acknowledge is recognised.
		@(negedge clock_in);
		rd = bus_out;
		@(posedge clock_in);
		#1;
		as_n_out = 1'b1;
		ds_n_out = 1'b1;
		drv_r = 1'b0;
		@(posedge clock_in);
		#1;
	endtask : cycle
	// Fast-termination read: the master samples data after two clocks and ends the cycle itself on the third.
	task automatic fast_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] rd);
		addr_out = a;
		rnw_out = 1'b1;
		size_out = SIZE_WORD;
		drv_r = 1'b0;
		as_n_out = 1'b0;
		ds_n_out = 1'b0;
		repeat (2) @(posedge clock_in);
		@(negedge clock_in);
		rd = bus_out;
		@(posedge clock_in);
		#1;
		as_n_out = 1'b1;
		ds_n_out = 1'b1;
		@(posedge clock_in);
		#1;
	endtask : fast_read
	// A long word on a 16-bit port goes out as two word cycles.
	task automatic long_write(input logic [ADDR_W-1:0] a, input logic [31:0] lw, input int lim,
		output logic [7:0] t);
		logic [DATA_W-1:0] rd;
		cycle(1'b0, a, SIZE_LONG, lw[31:16], lim, t[7:4], rd);
		cycle(1'b0, a + 24'h2, SIZE_WORD, lw[15:0], lim, t[3:0], rd);
	endtask : long_write
endmodule : bus_master_model
`default_nettype wire

// ### test/bus_slave_tb.sv
// Self-checking bench for the bus slave and its write FIFO.
`default_nettype none
module bus_slave_tb
	import slave_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clock_in = 1'b0;
	logic              rst_n_in = 1'b0;
	logic              narrow = 1'b0;
	logic              rd_valid = 1'b0;
	logic              retry_req = 1'b0;
	logic              wr_ready = 1'b0;
	logic [DATA_W-1:0] rd_data = '0;
	logic [ADDR_W-1:0] addr;
	logic              as_n, ds_n, rnw, soe, rd_ready, wr_valid;
	logic [1:0]        size, lanes;
	logic [DATA_W-1:0] bus, sdata, wr_data;
	logic [3:0]        term_n;
	logic [17:0]       q[$];
	int                mismatches = 0;
	int                num_checks = 0;
	int                cyc = 0;
	bus_slave bus_slave_inst (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr), .addr_valid_strobe_n_in(as_n),
		.data_strobe_n_in(ds_n), .read_not_write_in(rnw), .size_code_hi_in(size[1]),
		.size_code_lo_in(size[0]), .data_in(bus), .data_out(sdata), .data_oe_out(soe),
		.transfer_ack_wide_n_out(term_n[3]), .transfer_ack_narrow_n_out(term_n[2]),
		.bus_error_n_out(term_n[1]), .retry_n_out(term_n[0]), .port_narrow_in(narrow),
		.rd_data_in(rd_data), .rd_valid_in(rd_valid), .rd_ready_out(rd_ready),
		.retry_req_in(retry_req), .wr_data_out(wr_data), .wr_lanes_out(lanes),
		.wr_valid_out(wr_valid), .wr_ready_in(wr_ready));
	bus_master_model bus_master_model_inst (
		.clock_in(clock_in), .addr_out(addr), .as_n_out(as_n), .ds_n_out(ds_n), .rnw_out(rnw),
		.size_out(size), .bus_out(bus), .sdata_in(sdata), .soe_in(soe), .term_n_in(term_n));
	// Clock and a hang limit well above the expected run.
	always #10 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end
	// Lanes the slave should use for this address and size.
	function automatic logic [1:0] lane_mask(input logic a0, input logic [1:0] sz);
		return narrow ? LANE_UPPER : {!a0, a0 | (sz != SIZE_BYTE)};
	endfunction : lane_mask
	function automatic logic [DATA_W-1:0] bits(input logic [1:0] m);
		return {{8{m[1]}}, {8{m[0]}}};
	endfunction : bits
	task automatic check(input string what, input logic [DATA_W-1:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : check
	// Random access of any size inside the window; only byte and three-byte sizes go odd.
	task automatic pick(output logic [1:0] sz, output logic [ADDR_W-1:0] a);
		sz = 2'($urandom);
		a = {8'h00, 15'($urandom), sz[0] & 1'($urandom)};
	endtask : pick
	task automatic xfer(input logic r, input logic [ADDR_W-1:0] a, input logic [1:0] sz,
		input logic [DATA_W-1:0] wd, input int lim, input logic [3:0] et,
		output logic [DATA_W-1:0] rd);
		logic [3:0] t;
		bus_master_model_inst.cycle(r, a, sz, wd, lim, t, rd);
		check("termination", {12'h0, et}, {12'h0, t});
		check("release", 16'h000f, {12'h0, term_n});
	endtask : xfer
	task automatic results();
		$display("Checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	// Main sequence: fill, refuse, drain, reads, wait states, errors.
	initial begin
		logic [DATA_W-1:0] d, rd;
		logic [ADDR_W-1:0] a;
		logic [1:0]        sz;
		logic [31:0]       lw;
		logic [7:0]        t2;
		void'($urandom(32'h136b));
		repeat (8) @(posedge clock_in);
		#1;
		rst_n_in = 1'b1;
		check("idle", 16'h000f, {11'h0, soe, term_n});
		for (int i = 0; i < 12; i++) begin
			narrow = 1'($urandom);
			pick(sz, a);
			d = 16'($urandom);
			q.push_back({lane_mask(a[0], sz), d});
			xfer(1'b0, a, sz, d, 50, narrow ? 4'hb : 4'h7, rd);
		end
		narrow = 1'b0;
		for (int i = 0; i < 2; i++) begin
			lw = $urandom;
			q.push_back({LANE_BOTH, lw[31:16]});
			q.push_back({LANE_BOTH, lw[15:0]});
			bus_master_model_inst.long_write({8'h00, 1'b0, 14'($urandom), 1'b0}, lw, 50, t2);
			check("long ack", 16'h0077, {8'h0, t2});
		end
		xfer(1'b0, 24'h000040, SIZE_WORD, 16'hdead, 20, 4'hf, rd);
		for (int n = 0; n < 300 && q.size() > 0; n++) begin
			wr_ready = 1'($urandom);
			if (wr_ready && wr_valid) begin
				check("wdata", bits(q[0][17:16]) & q[0][15:0], bits(q[0][17:16]) & wr_data);
				check("lanes", {14'h0, q[0][17:16]}, {14'h0, lanes});
				void'(q.pop_front());
			end
			@(posedge clock_in);
			#1;
		end
		wr_ready = 1'b0;
		check("drained", 16'h0, {15'h0, wr_valid} | 16'(q.size()));
		rd_valid = 1'b1;
		for (int i = 0; i < 10; i++) begin
			narrow = 1'($urandom);
			pick(sz, a);
			rd_data = 16'($urandom);
			d = narrow ? {a[0] ? rd_data[7:0] : rd_data[15:8], 8'h00} : rd_data;
			xfer(1'b1, a, sz, 16'h0, 50, narrow ? 4'hb : 4'h7, rd);
			check("rdata", bits(lane_mask(a[0], sz)) & d, bits(lane_mask(a[0], sz)) & rd);
		end
		narrow = 1'b0;
		bus_master_model_inst.fast_read(24'h000200, rd);
		check("fast rdata", rd_data, rd);
		check("fast release", 16'h000f, {12'h0, term_n});
		rd_valid = 1'b0;
		fork
			xfer(1'b1, 24'h000100, SIZE_WORD, 16'h0, 50, 4'h7, rd);
			begin
				repeat (6) @(posedge clock_in);
				#1;
				rd_data = 16'hc3a5;
				rd_valid = 1'b1;
			end
		join
		check("late rdata", 16'hc3a5, rd);
		xfer(1'b1, 24'h010000, SIZE_WORD, 16'h0, 50, 4'hd, rd);
		xfer(1'b0, 24'h7f0002, SIZE_WORD, 16'h1234, 50, 4'hd, rd);
		retry_req = 1'b1;
		xfer(1'b1, 24'h000010, SIZE_WORD, 16'h0, 50, 4'hc, rd);
		retry_req = 1'b0;
		check("no stray push", 16'h0, {15'h0, wr_valid});
		results();
	end
endmodule : bus_slave_tb
`default_nettype wire
